// ===== verilog/exec_params.svh
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ==========================================================
// register map (byte addresses on the apb bus)
`define OFF_CMD 12'h000
`define OFF_STAT 12'h004
`define OFF_FLAGS 12'h008
`define OFF_ZPTR 12'h00c
`define BASE_GPR 4'h1
`define BASE_IO 4'h2
`define BASE_PM 4'h4
`define NUM_GPR 32

// ==========================================================
// command word fields
`define CMD_OP_MSB 4
`define CMD_OP_LSB 0
`define CMD_REG_MSB 12
`define CMD_REG_LSB 8
`define CMD_BIT_MSB 18
`define CMD_BIT_LSB 16
`define CMD_PORT_MSB 29
`define CMD_PORT_LSB 24

// ==========================================================
// state word fields
`define STAT_BUSY 0
`define STAT_SP_LSB 8

// ==========================================================
// status register bit positions, and reset values of the flags, Z pointer, data bytes and words
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define FLAGS_RESET 8'h00
`define ZPTR_RESET 16'h0000
`define DATA_RESET 8'h00
`define WORD_RESET 16'h0000

// ==========================================================
// execution lengths in core cycles
`define CYC_PM_READ 2'h3
`define CYC_PM_WRITE 2'h1
`define CYC_STACK 2'h2
`define CYC_IO_BIT 2'h2
`define CYC_SINGLE 2'h1

`endif

// ===== verilog/exec_pkg.sv
package exec_pkg;

	// ==========================================================
	// operation codes, in command-word order starting at zero
	typedef enum logic [4:0] {
		op_pm_read_r0,
		op_pm_read,
		op_pm_read_inc,
		op_pm_write,
		op_port_in,
		op_port_out,
		op_push,
		op_pop,
		op_io_bit_set,
		op_io_bit_clear,
		op_shift_left_logical,
		op_shift_right_logical,
		op_rotate_left_carry,
		op_rotate_right_carry,
		op_shift_right_arith,
		op_swap,
		op_status_bit_set,
		op_status_bit_clear,
		op_bit_to_transfer_flag,
		op_transfer_flag_to_bit,
		op_interrupts_on,
		op_interrupts_off,
		op_overflow_set,
		op_overflow_clear
	} op_t;

	typedef enum logic {st_idle, st_exec} state_t;

	typedef enum logic [2:0] {
		rg_none, rg_cmd, rg_stat, rg_flags, rg_zptr, rg_gpr, rg_io, rg_pm
	} region_t;

endpackage

// ===== verilog/shift_unit.sv
`timescale 1ns/1ps

module shift_unit
	import exec_pkg::*;
(
	input wire op_t op,
	input wire logic [7:0] value,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out
);

	always_comb begin
		result = value;
		carry_out = carry_in;
		case (op)
			op_shift_left_logical: begin
				result = {value[6:0], 1'b0};
				carry_out = value[7];
			end
			op_shift_right_logical: begin
				result = {1'b0, value[7:1]};
				carry_out = value[0];
			end
			op_rotate_left_carry: begin
				result = {value[6:0], carry_in};
				carry_out = value[7];
			end
			op_rotate_right_carry: begin
				result = {carry_in, value[7:1]};
				carry_out = value[0];
			end
			op_shift_right_arith: begin
				result = {value[7], value[7:1]};
				carry_out = value[0];
			end
			default: begin
				result = value;
				carry_out = carry_in;
			end
		endcase
	end

endmodule // shift_unit

// ===== verilog/bit_shift_exec.sv
`timescale 1ns/1ps
`include "exec_params.svh"

// Notes on behaviour
// - program read: Z byte, three cycles
// - program write stores R1:R0 at Z
// - push: register to stack, two cycles
// - pop: stack to register, two cycles
// - io bit set, others kept, two cycles
// - io bit clear, others kept, two cycles
// - shift left, zero in, flags ZCNV
// - shift right, zero in, flags ZCNV
// - rotate left via carry, flags ZCNV
// - rotate right via carry, flags ZCNV
// - arithmetic right keeps sign, flags ZCNV
// - nibble swap, one cycle, no flags
// - register bit to transfer flag only
// - transfer flag into register bit
// - set or clear any status flag
// - interrupt enable on and off, one cycle
// - overflow set and clear, only that flag
module bit_shift_exec
	import exec_pkg::*;
#(
	parameter int PM_WORDS = 64,
	parameter int IO_REGS = 64,
	parameter int STACK_DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy,
	output logic int_enable
);

	localparam int PMW = $clog2(PM_WORDS);
	localparam int IOW = $clog2(IO_REGS);
	localparam int SPW = $clog2(STACK_DEPTH);

	// the port field is six bits and the windows hold 64 words
	if (IO_REGS < 2 || IO_REGS > 64 || (1 << IOW) != IO_REGS)
		$error("IO_REGS must be a power of two, 2 to 64");
	if (PM_WORDS < 2 || PM_WORDS > 64 || (1 << PMW) != PM_WORDS)
		$error("PM_WORDS must be a power of two, 2 to 64");
	if (STACK_DEPTH < 2 || STACK_DEPTH > 256 ||
	    (1 << SPW) != STACK_DEPTH)
		$error("STACK_DEPTH must be a power of two, 2 to 256");

	// ==========================================================
	// address decode
	function automatic region_t region(input logic [11:0] a);
		int idx;
		idx = int'(a[7:2]);
		region = rg_none;
		if (a == `OFF_CMD)
			region = rg_cmd;
		else if (a == `OFF_STAT)
			region = rg_stat;
		else if (a == `OFF_FLAGS)
			region = rg_flags;
		else if (a == `OFF_ZPTR)
			region = rg_zptr;
		else if (a[1:0] == 2'h0) begin
			if (a[11:8] == `BASE_GPR && idx < `NUM_GPR)
				region = rg_gpr;
			else if (a[11:8] == `BASE_IO && idx < IO_REGS)
				region = rg_io;
			else if (a[11:8] == `BASE_PM && idx < PM_WORDS)
				region = rg_pm;
		end
	endfunction

	function automatic logic [1:0] cycles(input op_t op);
		case (op)
			op_pm_read_r0, op_pm_read, op_pm_read_inc:
				cycles = `CYC_PM_READ;
			op_pm_write: cycles = `CYC_PM_WRITE;
			op_push, op_pop: cycles = `CYC_STACK;
			op_io_bit_set, op_io_bit_clear:
				cycles = `CYC_IO_BIT;
			default: cycles = `CYC_SINGLE;
		endcase
	endfunction

	// ==========================================================
	// state
	logic [7:0] gpr_q [`NUM_GPR];
	logic [7:0] gpr_d [`NUM_GPR];
	logic [7:0] io_q [IO_REGS];
	logic [7:0] io_d [IO_REGS];
	logic [7:0] stk_q [STACK_DEPTH];
	logic [7:0] stk_d [STACK_DEPTH];
	logic [15:0] pm_q [PM_WORDS];
	logic [15:0] pm_d [PM_WORDS];
	logic [7:0] flags_q, flags_d;
	logic [15:0] z_q, z_d;
	logic [SPW-1:0] sp_q, sp_d;
	state_t state_q, state_d;
	logic [1:0] cnt_q, cnt_d;
	op_t op_q, op_d;
	logic [4:0] reg_q, reg_d;
	logic [2:0] bit_q, bit_d;
	logic [5:0] port_q, port_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic busy_q, busy_d;

	region_t rg;
	logic acc, done, start, commit, op_ok;
	op_t cmd_op;
	logic [7:0] cur_val, sh_res, pm_byte;
	logic [15:0] pm_word;
	logic sh_c;

	assign rg = region(paddr);
	assign acc = psel & penable;
	// the access ends one cycle after it opens: one wait state
	assign done = acc & pready_q;
	assign cmd_op = op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
	assign op_ok = pwdata[`CMD_OP_MSB:`CMD_OP_LSB] <= op_overflow_clear;
	assign start = done & pwrite & (rg == rg_cmd) &
		(state_q == st_idle) & op_ok;
	assign commit = (state_q == st_exec) && (cnt_q == 2'h0);
	assign cur_val = gpr_q[reg_q];
	assign pm_word = pm_q[z_q[PMW:1]];
	assign pm_byte = z_q[0] ? pm_word[15:8] : pm_word[7:0];

	shift_unit shift_unit_inst (
		.op(op_q),
		.value(cur_val),
		.carry_in(flags_q[`FLAG_C]),
		.result(sh_res),
		.carry_out(sh_c)
	);

	// ==========================================================
	// bus answer
	always_comb begin
		prdata_d = prdata_q;
		pready_d = acc & ~pready_q;
		pslverr_d = 1'b0;
		if (acc & ~pready_q) begin
			prdata_d = 32'h0000_0000;
			case (rg)
				rg_stat: begin
					prdata_d[`STAT_BUSY] = busy_q;
					prdata_d[`STAT_SP_LSB +: SPW] = sp_q;
				end
				rg_flags: prdata_d[7:0] = flags_q;
				rg_zptr: prdata_d[15:0] = z_q;
				rg_gpr: prdata_d[7:0] = gpr_q[paddr[6:2]];
				rg_io: prdata_d[7:0] = io_q[paddr[IOW+1:2]];
				rg_pm: prdata_d[15:0] = pm_q[paddr[PMW+1:2]];
				default: prdata_d = 32'h0000_0000;
			endcase
			// refused: unmapped, read-only written, bad or busy command
			pslverr_d = (rg == rg_none) ||
				(pwrite && rg == rg_stat) ||
				(pwrite && rg == rg_cmd &&
				 (state_q != st_idle || !op_ok));
		end
	end

	// ==========================================================
	// execution
	always_comb begin
		gpr_d = gpr_q;
		io_d = io_q;
		stk_d = stk_q;
		pm_d = pm_q;
		flags_d = flags_q;
		z_d = z_q;
		sp_d = sp_q;
		state_d = state_q;
		cnt_d = cnt_q;
		op_d = op_q;
		reg_d = reg_q;
		bit_d = bit_q;
		port_d = port_q;
		if (done & pwrite) begin
			case (rg)
				rg_flags: flags_d = pwdata[7:0];
				rg_zptr: z_d = pwdata[15:0];
				rg_gpr: gpr_d[paddr[6:2]] = pwdata[7:0];
				rg_io: io_d[paddr[IOW+1:2]] = pwdata[7:0];
				rg_pm: pm_d[paddr[PMW+1:2]] = pwdata[15:0];
				default: ;
			endcase
		end
		if (start) begin
			state_d = st_exec;
			cnt_d = cycles(cmd_op) - 2'h1;
			op_d = cmd_op;
			reg_d = pwdata[`CMD_REG_MSB:`CMD_REG_LSB];
			bit_d = pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
			port_d = pwdata[`CMD_PORT_MSB:`CMD_PORT_LSB];
		end else if (state_q == st_exec && !commit) begin
			cnt_d = cnt_q - 2'h1;
		end
		if (commit) begin
			state_d = st_idle;
			case (op_q)
				op_pm_read_r0: gpr_d[0] = pm_byte;
				op_pm_read: gpr_d[reg_q] = pm_byte;
				op_pm_read_inc: begin
					gpr_d[reg_q] = pm_byte;
					z_d = z_q + 16'h0001;
				end
				op_pm_write:
					pm_d[z_q[PMW:1]] = {gpr_q[1], gpr_q[0]};
				op_port_in: gpr_d[reg_q] = io_q[port_q[IOW-1:0]];
				op_port_out: io_d[port_q[IOW-1:0]] = cur_val;
				op_push: begin
					stk_d[sp_q] = cur_val;
					sp_d = sp_q + 1'b1;
				end
				op_pop: begin
					gpr_d[reg_q] = stk_q[sp_q - 1'b1];
					sp_d = sp_q - 1'b1;
				end
				op_io_bit_set: io_d[port_q[IOW-1:0]][bit_q] = 1'b1;
				op_io_bit_clear:
					io_d[port_q[IOW-1:0]][bit_q] = 1'b0;
				op_shift_left_logical, op_shift_right_logical,
				op_rotate_left_carry, op_rotate_right_carry,
				op_shift_right_arith: begin
					// signed-test flag left alone: only Z,C,N,V move
					gpr_d[reg_q] = sh_res;
					flags_d[`FLAG_C] = sh_c;
					flags_d[`FLAG_N] = sh_res[7];
					flags_d[`FLAG_V] = sh_res[7] ^ sh_c;
					flags_d[`FLAG_Z] = (sh_res == `DATA_RESET);
				end
				op_swap: gpr_d[reg_q] = {cur_val[3:0], cur_val[7:4]};
				op_status_bit_set: flags_d[bit_q] = 1'b1;
				op_status_bit_clear: flags_d[bit_q] = 1'b0;
				op_bit_to_transfer_flag:
					flags_d[`FLAG_T] = cur_val[bit_q];
				op_transfer_flag_to_bit:
					gpr_d[reg_q][bit_q] = flags_q[`FLAG_T];
				op_interrupts_on: flags_d[`FLAG_I] = 1'b1;
				op_interrupts_off: flags_d[`FLAG_I] = 1'b0;
				op_overflow_set: flags_d[`FLAG_V] = 1'b1;
				op_overflow_clear: flags_d[`FLAG_V] = 1'b0;
				default: ;
			endcase
		end
		busy_d = (state_d == st_exec);
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `NUM_GPR; i++) gpr_q[i] <= `DATA_RESET;
			for (int i = 0; i < IO_REGS; i++) io_q[i] <= `DATA_RESET;
			for (int i = 0; i < STACK_DEPTH; i++) stk_q[i] <= `DATA_RESET;
			for (int i = 0; i < PM_WORDS; i++) pm_q[i] <= `WORD_RESET;
			flags_q <= `FLAGS_RESET;
			z_q <= `ZPTR_RESET;
			sp_q <= '0;
			state_q <= st_idle;
			cnt_q <= 2'h0;
			op_q <= op_pm_read_r0;
			reg_q <= 5'h00;
			bit_q <= 3'h0;
			port_q <= 6'h00;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			gpr_q <= gpr_d;
			io_q <= io_d;
			stk_q <= stk_d;
			pm_q <= pm_d;
			flags_q <= flags_d;
			z_q <= z_d;
			sp_q <= sp_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			reg_q <= reg_d;
			bit_q <= bit_d;
			port_q <= port_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			busy_q <= busy_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign busy = busy_q;
	assign int_enable = flags_q[`FLAG_I];

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic cur_msb, cur_lsb, sel_bit;
	logic [3:0] cur_hi, cur_lo;
	assign cur_msb = cur_val[7];
	assign cur_lsb = cur_val[0];
	assign sel_bit = cur_val[bit_q];
	assign cur_hi = cur_val[7:4];
	assign cur_lo = cur_val[3:0];

	sequence s_busy3;
		busy_q [*3] ##1 !busy_q;
	endsequence
	sequence s_busy2;
		busy_q [*2] ##1 !busy_q;
	endsequence

	a_pm_read_time:
	assert property (start && cmd_op == op_pm_read_inc |=> s_busy3)
	else $error("program read not three cycles");

	a_stack_time:
	assert property (start && cmd_op inside {op_push, op_pop} |=> s_busy2)
	else $error("stack access not two cycles");

	a_io_set_bit:
	assert property (start && cmd_op == op_io_bit_set
		|=> s_busy2 ##0 io_q[port_q[IOW-1:0]][bit_q])
	else $error("io bit not set after two cycles");

	a_shl_result:
	assert property (commit && op_q == op_shift_left_logical
		|=> !gpr_q[reg_q][0] && flags_q[`FLAG_C] == $past(cur_msb))
	else $error("left shift result or carry wrong");

	a_ror_result:
	assert property (commit && op_q == op_rotate_right_carry
		|=> gpr_q[reg_q][7] == $past(flags_q[`FLAG_C]) &&
		flags_q[`FLAG_C] == $past(cur_lsb))
	else $error("right rotate through carry wrong");

	a_swap_nibbles:
	assert property (commit && op_q == op_swap && !(done & pwrite)
		|=> gpr_q[reg_q] == {$past(cur_lo), $past(cur_hi)} &&
		flags_q == $past(flags_q))
	else $error("nibble swap wrong or flags moved");

	a_transfer_store:
	assert property (commit && op_q == op_bit_to_transfer_flag &&
		!(done & pwrite)
		|=> flags_q[`FLAG_T] == $past(sel_bit) &&
		flags_q[5:0] == $past(flags_q[5:0]) &&
		flags_q[`FLAG_I] == $past(flags_q[`FLAG_I]))
	else $error("transfer flag store wrong");

	a_int_enable_out:
	assert property (start && cmd_op == op_interrupts_on |=> ##1 int_enable)
	else $error("interrupt enable not set in one cycle");

	a_ovf_clear:
	assert property (commit && op_q == op_overflow_clear && !(done & pwrite)
		|=> !flags_q[`FLAG_V] && flags_q[2:0] == $past(flags_q[2:0]) &&
		flags_q[7:4] == $past(flags_q[7:4]))
	else $error("overflow clear touched other flags");

	a_bus_answer:
	assert property (psel && !penable ##1 psel && penable
		|-> ##[0:1] pready)
	else $error("apb access not answered");

endmodule // bit_shift_exec

// ===== test/bit_shift_flag_and_memop_exec_tb_top.sv
`timescale 1ns/1ps
`include "exec_params.svh"
module bit_shift_flag_and_memop_exec_tb_top
	import exec_pkg::*;
;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, busy, int_enable;
	int n_fail = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic err;
	logic [7:0] s_exp;
	logic [8:0] cr;
	logic [7:0] tv [4] = '{8'h80, 8'h01, 8'ha5, 8'h00};

	always #12.5 pclk = ~pclk;

	bit_shift_exec bit_shift_exec_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy), .int_enable(int_enable));

	// ==========================================================
	// checking and bus tasks
	task chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task finish_test;
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// request held until pready is sampled high, then released
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0000_0000);
		chk(nm, rd, e);
	endtask

	function automatic logic [11:0] ga(input int i, input int base);
		return 12'(base + 4 * i);
	endfunction

	// busy is counted from the edge after the command write completes
	task do_op(input op_t op, input int rg, b, pt, nc);
		int n;
		apb(1, `OFF_CMD, {2'b0, 6'(pt), 5'b0, 3'(b), 3'b0, 5'(rg), 3'b0, op});
		chk("cmd_err", 32'(err), 32'h0000_0000);
		n = 0;
		@(posedge pclk);
		while (busy === 1'b1 && n < 10) begin
			n++;
			@(posedge pclk);
		end
		chk("cycles", n, nc);
	endtask

	function automatic logic [8:0] shref(input int op, logic [7:0] v, logic c);
		case (op)
			10: return {v[7], v[6:0], 1'b0};
			11: return {v[0], 1'b0, v[7:1]};
			12: return {v[7], v[6:0], c};
			13: return {v[0], c, v[7:1]};
			default: return {v[0], v[7], v[7:1]};
		endcase
	endfunction

	// ==========================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		finish_test;
	end

	// ==========================================================
	// tests
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("int_enable", 32'(int_enable), 32'h0000_0000);
		rchk("status_rst", `OFF_FLAGS, 32'h0000_0000);
		apb(0, 12'h0f0, 32'h0000_0000);
		chk("unmapped_err", 32'(err), 32'h0000_0001);
		apb(1, `OFF_STAT, 32'h0000_0001);
		chk("stat_wr_err", 32'(err), 32'h0000_0001);
		apb(1, 12'h102, 32'h0000_0001);
		chk("misalign_err", 32'(err), 32'h0000_0001);
		apb(1, `OFF_CMD, 32'h0000_0018);
		chk("bad_op_err", 32'(err), 32'h0000_0001);
		s_exp = 8'h00;
		for (int i = 0; i < 16; i++) begin
			do_op(i < 8 ? op_status_bit_set : op_status_bit_clear,
				0, i % 8, 0, 1);
			s_exp[i % 8] = (i < 8);
			rchk("flag_set_clr", `OFF_FLAGS, 32'(s_exp));
			chk("int_pin", 32'(int_enable), 32'(s_exp[7]));
		end
		// target bit starts opposite to its end value, others preset
		for (int i = 0; i < 4; i++) begin
			s_exp = 8'h74 | (i == 1 ? 8'h80 : 8'h00) | (i == 3 ? 8'h08 : 8'h00);
			apb(1, `OFF_FLAGS, 32'(s_exp));
			do_op(op_t'(20 + i), 0, 0, 0, 1);
			s_exp = 8'h74 | (i == 0 ? 8'h80 : 8'h00) | (i == 2 ? 8'h08 : 8'h00);
			rchk("int_ovf", `OFF_FLAGS, 32'(s_exp));
			chk("int_pin_op", 32'(int_enable), 32'(s_exp[7]));
		end
		for (int op = 10; op < 15; op++)
			for (int j = 0; j < 8; j++) begin
				s_exp = 8'h70 | 8'(j % 2);
				apb(1, `OFF_FLAGS, 32'(s_exp));
				apb(1, ga(5, 'h100), 32'(tv[j / 2]));
				cr = shref(op, tv[j / 2], s_exp[0]);
				do_op(op_t'(op), 5, 0, 0, 1);
				rchk("shift_res", ga(5, 'h100), 32'(cr[7:0]));
				s_exp = {s_exp[7:4], cr[7] ^ cr[8], cr[7], cr[7:0] == 0, cr[8]};
				rchk("shift_flags", `OFF_FLAGS,
					32'(s_exp));
			end
		apb(1, ga(6, 'h100), 32'h0000_003c);
		do_op(op_swap, 6, 0, 0, 1);
		rchk("swap", ga(6, 'h100), 32'h0000_00c3);
		rchk("swap_flags", `OFF_FLAGS, 32'(s_exp));
		// mixed flags preset so that a stray flag change shows up
		apb(1, `OFF_FLAGS, 32'h0000_002a);
		apb(1, ga(6, 'h100), 32'h0000_0008);
		apb(1, ga(7, 'h100), 32'h0000_0081);
		do_op(op_bit_to_transfer_flag, 6, 3, 0, 1);
		rchk("to_t", `OFF_FLAGS, 32'h0000_006a);
		do_op(op_transfer_flag_to_bit, 7, 5, 0, 1);
		rchk("from_t", ga(7, 'h100), 32'h0000_00a1);
		rchk("from_t_flags", `OFF_FLAGS, 32'h0000_006a);
		do_op(op_bit_to_transfer_flag, 6, 2, 0, 1);
		rchk("to_t_zero", `OFF_FLAGS, 32'h0000_002a);
		apb(1, ga(10, 'h200), 32'h0000_005a);
		do_op(op_io_bit_set, 0, 0, 10, 2);
		rchk("io_set", ga(10, 'h200), 32'h0000_005b);
		do_op(op_io_bit_clear, 0, 6, 10, 2);
		rchk("io_clr", ga(10, 'h200), 32'h0000_001b);
		do_op(op_port_out, 6, 0, 11, 1);
		rchk("port_out", ga(11, 'h200), 32'h0000_0008);
		do_op(op_port_in, 8, 0, 10, 1);
		rchk("port_in", ga(8, 'h100), 32'h0000_001b);
		apb(1, ga(9, 'h100), 32'h0000_00c7);
		do_op(op_push, 9, 0, 0, 2);
		do_op(op_push, 6, 0, 0, 2);
		rchk("stack_ptr", `OFF_STAT, 32'h0000_0200);
		do_op(op_pop, 12, 0, 0, 2);
		do_op(op_pop, 13, 0, 0, 2);
		rchk("pop_last", ga(12, 'h100), 32'h0000_0008);
		rchk("pop_first", ga(13, 'h100), 32'h0000_00c7);
		apb(1, ga(3, 'h400), 32'h0000_beef);
		apb(1, `OFF_ZPTR, 32'h0000_0007);
		do_op(op_pm_read_r0, 0, 0, 0, 3);
		rchk("pm_r0", ga(0, 'h100), 32'h0000_00be);
		apb(1, `OFF_ZPTR, 32'h0000_0006);
		do_op(op_pm_read_inc, 13, 0, 0, 3);
		rchk("pm_inc", ga(13, 'h100), 32'h0000_00ef);
		rchk("z_inc", `OFF_ZPTR, 32'h0000_0007);
		do_op(op_pm_read, 14, 0, 0, 3);
		rchk("pm_rd", ga(14, 'h100), 32'h0000_00be);
		rchk("pm_flags", `OFF_FLAGS, 32'h0000_002a);
		apb(1, ga(1, 'h100), 32'h0000_0012);
		apb(1, ga(0, 'h100), 32'h0000_0034);
		apb(1, `OFF_ZPTR, 32'h0000_0008);
		do_op(op_pm_write, 0, 0, 0, 1);
		rchk("pm_wr", ga(4, 'h400), 32'h0000_1234);
		finish_test;
	end
endmodule // bit_shift_flag_and_memop_exec_tb_top
